// ==== rtl/dram_ctrl_cfg.svh ====
// Purpose: Offsets, field positions and timing counts of the DRAM controller
// Assumes: Included by bare name
// Notes:   Memory timings count memory clock periods
`ifndef DRAM_CTRL_CFG_SVH
`define DRAM_CTRL_CFG_SVH
`define NUM_PORTS        8
`define RSVD_PORT        1
`define BANK_SEL_MSB     27
`define BANK_SEL_LSB     26
`define DLY_TAP_W        7
`define PAD_MODE_BIT     0
`define COL_BASE         5'h08
`define ROW_BASE         5'h0b
`define MEM_CLK_MAX_MHZ  133
`define T_RCD_NS         20
`define T_RP_NS          20
`define T_RCD_CYC ((`T_RCD_NS * `MEM_CLK_MAX_MHZ + 999) / 1000)
`define T_RP_CYC  ((`T_RP_NS * `MEM_CLK_MAX_MHZ + 999) / 1000)
`define CAS_LAT          2
`define SYNC_TICKS       1
`define WR_REC_CYC       1
`define ZOUT_00          6'h19
`define ZOUT_01          6'h23
`define ZOUT_10          6'h2d
`define ZOUT_11          6'h37
`endif

// ==== rtl/dram_ctrl_pkg.sv ====
// Purpose: Types shared by the DRAM controller files
// Assumes: Nothing
// Notes:   Gray codes along the usual path except the step back to idle
package dram_ctrl_pkg;
  typedef enum logic [1:0] {
    ARB_IDLE = 2'h0,
    ARB_BUSY = 2'h1,
    ARB_DONE = 2'h3
  } arb_state_t;
  typedef enum logic [2:0] {
    LK_IDLE = 3'h0,
    LK_GAP  = 3'h1,
    LK_RW   = 3'h3,
    LK_LAT  = 3'h2,
    LK_PRE  = 3'h6
  } link_state_t;
  typedef enum logic [1:0] {
    MODE_SDR32 = 2'h0,
    MODE_SDR16 = 2'h1,
    MODE_DDR16 = 2'h2
  } mem_mode_t;
  typedef struct packed {
    logic [1:0]  cs;
    logic [1:0]  bank;
    logic [12:0] row;
    logic [10:0] col;
  } dram_loc_t;
endpackage

// ==== rtl/dram_link.sv ====
// Purpose: Memory-side sequencer on the link clock
// Assumes: cmd_* stable while cmd_toggle differs from done_toggle
// Notes:   Memory clock is link clock divided by two
`timescale 1ns/1ps
`include "dram_ctrl_cfg.svh"
module dram_link (
  input  wire logic        mem_clk,
  input  wire logic        srst,
  input  wire logic        cmd_toggle,
  input  wire logic        cmd_write,
  input  wire logic        cmd_half,
  input  wire logic [1:0]  cmd_cs,
  input  wire logic [1:0]  cmd_bank,
  input  wire logic [12:0] cmd_row,
  input  wire logic [10:0] cmd_col,
  input  wire logic [31:0] cmd_wdata,
  input  wire logic [3:0]  cmd_mask,
  output logic             done_toggle,
  output logic [31:0]      rd_data,
  output logic [1:0]       dram_clock_out,
  output logic [1:0]       dram_clock_out_inv,
  output logic [1:0]       dram_clock_enable_out,
  output logic [3:0]       dram_byte_mask,
  output logic             row_strobe_n,
  output logic             column_strobe_n,
  output logic             write_strobe_n,
  output logic [3:0]       bank_select_n,
  output logic [14:0]      dram_address_out,
  output logic [31:0]      dram_data_out,
  output logic [31:0]      dram_data_oe,
  input  wire logic [31:0] dram_data_in
);
  logic        rst_s1, rst_s2, req_s1, req_s2, req_seen, phase, beat;
  logic [3:0]  cnt;
  logic [15:0] prev;
  logic [31:0] din_s1, din_s2;
  dram_ctrl_pkg::link_state_t state;
  wire         new_req = req_s2 != req_seen;
  wire  [3:0]  sel_n   = ~(4'h1 << cmd_cs);
  wire  [10:0] col_b   = cmd_col + {10'h000, beat};

  always_ff @(posedge mem_clk) begin
    rst_s1 <= srst;
    rst_s2 <= rst_s1;
    req_s1 <= cmd_toggle;
    req_s2 <= req_s1;
    din_s1 <= dram_data_in;
    din_s2 <= din_s1;
  end

  always_ff @(posedge mem_clk) begin
    if (rst_s2) begin
      state <= dram_ctrl_pkg::LK_IDLE;
      phase <= 1'h0;
      beat <= 1'h0;
      cnt <= 4'h0;
      prev <= 16'h0000;
      req_seen <= 1'h0;
      done_toggle <= 1'h0;
      rd_data <= 32'h0000_0000;
      dram_clock_out <= 2'h0;
      dram_clock_out_inv <= 2'h3;
      dram_clock_enable_out <= 2'h0;
      dram_byte_mask <= 4'hf;
      {row_strobe_n, column_strobe_n, write_strobe_n} <= 3'h7;
      bank_select_n <= 4'hf;
      dram_address_out <= 15'h0000;
      dram_data_out <= 32'h0000_0000;
      dram_data_oe <= 32'h0000_0000;
    end else begin
      phase <= ~phase;
      dram_clock_out <= {2{~phase}};
      dram_clock_out_inv <= {2{phase}};
      dram_clock_enable_out <= 2'h3;
      if (phase) begin
        {row_strobe_n, column_strobe_n, write_strobe_n} <= 3'h7;
        bank_select_n <= 4'hf;
        dram_data_oe <= 32'h0000_0000;
        prev <= din_s2[15:0];
        unique case (state)
          dram_ctrl_pkg::LK_IDLE: if (new_req) begin
            req_seen <= req_s2;
            bank_select_n <= sel_n;
            row_strobe_n <= 1'h0;
            dram_address_out <= {cmd_bank, cmd_row};
            cnt <= 4'(`T_RCD_CYC - 1);
            beat <= 1'h0;
            state <= dram_ctrl_pkg::LK_GAP;
          end
          dram_ctrl_pkg::LK_GAP: if (cnt == 4'h0) begin
            state <= dram_ctrl_pkg::LK_RW;
          end else begin
            cnt <= cnt - 4'h1;
          end
          dram_ctrl_pkg::LK_RW: begin
            bank_select_n <= sel_n;
            column_strobe_n <= 1'h0;
            write_strobe_n <= ~cmd_write;
            dram_address_out <= {cmd_bank, 1'h0, col_b[10], 1'h0, col_b[9:0]};
            if (cmd_half) begin
              dram_data_out <= {16'h0000, beat ? cmd_wdata[31:16] : cmd_wdata[15:0]};
              dram_data_oe <= {16'h0000, {16{cmd_write}}};
              dram_byte_mask <= {2'h3, beat ? cmd_mask[3:2] : cmd_mask[1:0]};
            end else begin
              dram_data_out <= cmd_wdata;
              dram_data_oe <= {32{cmd_write}};
              dram_byte_mask <= cmd_mask;
            end
            if (cmd_half && !beat) begin
              beat <= 1'h1;
            end else begin
              cnt <= cmd_write ? 4'(`WR_REC_CYC) : 4'(`CAS_LAT + `SYNC_TICKS);
              state <= dram_ctrl_pkg::LK_LAT;
            end
          end
          dram_ctrl_pkg::LK_LAT: if (cnt == 4'h0) begin
            if (!cmd_write) begin
              rd_data <= cmd_half ? {din_s2[15:0], prev} : din_s2;
            end
            bank_select_n <= sel_n;
            {row_strobe_n, write_strobe_n} <= 2'h0;
            dram_address_out <= 15'h0400;
            dram_byte_mask <= 4'hf;
            cnt <= 4'(`T_RP_CYC - 1);
            state <= dram_ctrl_pkg::LK_PRE;
          end else begin
            cnt <= cnt - 4'h1;
          end
          dram_ctrl_pkg::LK_PRE: if (cnt == 4'h0) begin
            done_toggle <= ~done_toggle;
            state <= dram_ctrl_pkg::LK_IDLE;
          end else begin
            cnt <= cnt - 4'h1;
          end
          default: state <= dram_ctrl_pkg::LK_IDLE;
        endcase
      end
    end
  end
endmodule

// ==== rtl/multiport_dram_ctrl.sv ====
// Purpose: Eight-port AHB front end of the DRAM controller
// Assumes: Config inputs come from logic on sys_clk
// Notes:   One access in flight; memory side runs on mem_clk
`timescale 1ns/1ps
`include "dram_ctrl_cfg.svh"
module multiport_dram_ctrl (
  input  wire logic             sys_clk,
  input  wire logic             srst,
  input  wire logic             mem_clk,
  input  wire logic [7:0]       hsel,
  input  wire logic [7:0][1:0]  htrans,
  input  wire logic [7:0]       hwrite,
  input  wire logic [7:0][2:0]  hsize,
  input  wire logic [7:0][2:0]  hburst,
  input  wire logic [7:0][31:0] haddr,
  input  wire logic [7:0][31:0] hwdata,
  input  wire logic [7:0]       hready,
  output logic [7:0][31:0]      hrdata,
  output logic [7:0]            hreadyout,
  output logic [7:0][1:0]       hresp,
  input  wire logic [1:0]       mem_mode,
  input  wire logic             geo_banks4,
  input  wire logic [1:0]       geo_row_sel,
  input  wire logic [1:0]       geo_col_sel,
  input  wire logic [7:0]       clock_out_setting,
  input  wire logic [7:0]       command_setting,
  input  wire logic [7:0]       strobe_low_setting,
  input  wire logic [7:0]       strobe_high_setting,
  input  wire logic [7:0]       pad_mode_ctl,
  input  wire logic [1:0]       impedance_ctl,
  output logic [6:0]            clock_out_delay,
  output logic [6:0]            delayed_bus_clock,
  output logic [6:0]            strobe_delay_low,
  output logic [6:0]            strobe_delay_high,
  output logic                  pad_cmos_mode,
  output logic                  impedance_sel_a,
  output logic                  impedance_sel_b,
  output logic [5:0]            drive_ohms,
  output logic                  busy,
  output logic [2:0]            grant_port,
  output logic [1:0]            dram_clock_out,
  output logic [1:0]            dram_clock_out_inv,
  output logic [1:0]            dram_clock_enable_out,
  output logic [3:0]            dram_byte_mask,
  output logic                  row_strobe_n,
  output logic                  column_strobe_n,
  output logic                  write_strobe_n,
  output logic [3:0]            bank_select_n,
  output logic [14:0]           dram_address_out,
  output logic [31:0]           dram_data_out,
  output logic [31:0]           dram_data_oe,
  input  wire logic [31:0]      dram_data_in
);

  // Lowest numbered set bit wins
  function automatic logic [2:0] first_set(input logic [7:0] v);
    logic [2:0] r;
    r = 3'h0;
    for (int i = 7; i >= 0; i--) begin
      if (v[i]) begin
        r = 3'(i);
      end
    end
    return r;
  endfunction

  // Byte address to bank select, bank, row, column
  function automatic dram_ctrl_pkg::dram_loc_t map_addr(
    input logic [27:0] a,
    input logic        half,
    input logic        b4,
    input logic [1:0]  rsel,
    input logic [1:0]  csel
  );
    logic [25:0] u;
    logic [4:0]  cw;
    logic [4:0]  rs;
    logic [4:0]  rw;
    dram_ctrl_pkg::dram_loc_t l;
    u = half ? {1'h0, a[25:1]} : {2'h0, a[25:2]};
    cw = `COL_BASE + {3'h0, csel};
    rs = `ROW_BASE + ((rsel == 2'h3) ? 5'h02 : {3'h0, rsel});
    rw = cw + (b4 ? 5'h02 : 5'h01);
    l.cs = a[`BANK_SEL_MSB:`BANK_SEL_LSB];
    l.col = 11'(u & ~(26'h3ff_ffff << cw));
    l.bank = b4 ? 2'(u >> cw) : {1'h0, 1'(u >> cw)};
    l.row = 13'((u >> rw) & ~(26'h3ff_ffff << rs));
    return l;
  endfunction

  // Masked lanes are high
  function automatic logic [3:0] lane_mask(
    input logic [2:0] sz,
    input logic [1:0] a
  );
    logic [3:0] en;
    unique case (sz)
      3'h0: en = 4'h1 << a;
      3'h1: en = a[1] ? 4'hc : 4'h3;
      default: en = 4'hf;
    endcase
    return ~en;
  endfunction

  function automatic logic [5:0] ohms(input logic [1:0] z);
    logic [5:0] r;
    unique case (z)
      2'h0: r = `ZOUT_00;
      2'h1: r = `ZOUT_01;
      2'h2: r = `ZOUT_10;
      default: r = `ZOUT_11;
    endcase
    return r;
  endfunction

  dram_ctrl_pkg::arb_state_t state;
  logic [7:0]       pending;
  logic [7:0][27:0] a_addr;
  logic [7:0]       a_write;
  logic [7:0][2:0]  a_size;
  logic [7:0][2:0]  a_burst;
  logic [2:0]       cur;
  logic             lock;
  logic [2:0]       lock_port;
  logic             req_toggle;
  logic             done_s1;
  logic             done_s2;
  logic             done_seen;
  logic             c_write;
  logic             c_half;
  logic [1:0]       c_cs;
  logic [1:0]       c_bank;
  logic [12:0]      c_row;
  logic [10:0]      c_col;
  logic [31:0]      c_wdata;
  logic [3:0]       c_mask;
  logic             done_toggle;
  logic [31:0]      rd_data;

  wire  [7:0]       addr_phase;
  wire  [7:0]       port_ok;
  wire  [1:0]       lock_trans;
  wire              lock_wait;
  wire  [2:0]       pick;
  wire              can_grant;
  wire              half_mode;
  wire              link_done;
  dram_ctrl_pkg::dram_loc_t pick_loc;

  for (genvar p = 0; p < `NUM_PORTS; p++) begin : g_port
    assign port_ok[p] = (p != `RSVD_PORT);
    assign addr_phase[p] = hsel[p] & hready[p] & htrans[p][1] & port_ok[p];
  end

  assign lock_trans = htrans[lock_port];
  assign lock_wait = lock & ~pending[lock_port] & lock_trans[0];
  assign pick = (lock & pending[lock_port]) ? lock_port : first_set(pending);
  assign can_grant = (state == dram_ctrl_pkg::ARB_IDLE) & (|pending) & ~lock_wait;
  assign half_mode = mem_mode != dram_ctrl_pkg::MODE_SDR32;
  assign pick_loc = map_addr(a_addr[pick], half_mode, geo_banks4,
                             geo_row_sel, geo_col_sel);
  assign link_done = done_s2 != done_seen;

  // Address phase capture
  always_ff @(posedge sys_clk) begin
    for (int p = 0; p < `NUM_PORTS; p++) begin
      if (addr_phase[p]) begin
        a_addr[p] <= haddr[p][27:0];
        a_write[p] <= hwrite[p];
        a_size[p] <= hsize[p];
        a_burst[p] <= hburst[p];
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    done_s1 <= done_toggle;
    done_s2 <= done_s1;
  end

  // Arbiter and port handshake
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      state <= dram_ctrl_pkg::ARB_IDLE;
      pending <= 8'h00;
      hreadyout <= 8'hff;
      hresp <= 16'h0000;
      hrdata <= 256'h0;
      cur <= 3'h0;
      lock <= 1'h0;
      lock_port <= 3'h0;
      req_toggle <= 1'h0;
      done_seen <= 1'h0;
      busy <= 1'h0;
      c_write <= 1'h0;
      c_half <= 1'h0;
      c_cs <= 2'h0;
      c_bank <= 2'h0;
      c_row <= 13'h0000;
      c_col <= 11'h000;
      c_wdata <= 32'h0000_0000;
      c_mask <= 4'hf;
    end else begin
      unique case (state)
        dram_ctrl_pkg::ARB_IDLE: begin
          if (lock & ~pending[lock_port] & ~lock_trans[0]) begin
            lock <= 1'h0;
          end
          if (can_grant) begin
            cur <= pick;
            c_write <= a_write[pick];
            c_half <= half_mode;
            c_cs <= pick_loc.cs;
            c_bank <= pick_loc.bank;
            c_row <= pick_loc.row;
            c_col <= pick_loc.col;
            c_wdata <= hwdata[pick];
            c_mask <= lane_mask(a_size[pick], a_addr[pick][1:0]);
            req_toggle <= ~req_toggle;
            busy <= 1'h1;
            state <= dram_ctrl_pkg::ARB_BUSY;
          end
        end
        dram_ctrl_pkg::ARB_BUSY: if (link_done) begin
          done_seen <= done_s2;
          if (!c_write) begin
            hrdata[cur] <= rd_data;
          end
          state <= dram_ctrl_pkg::ARB_DONE;
        end
        dram_ctrl_pkg::ARB_DONE: begin
          pending[cur] <= 1'h0;
          hreadyout[cur] <= 1'h1;
          lock <= a_burst[cur] != 3'h0;
          lock_port <= cur;
          busy <= 1'h0;
          state <= dram_ctrl_pkg::ARB_IDLE;
        end
        default: state <= dram_ctrl_pkg::ARB_IDLE;
      endcase
      for (int p = 0; p < `NUM_PORTS; p++) begin
        if (addr_phase[p]) begin
          pending[p] <= 1'h1;
          hreadyout[p] <= 1'h0;
        end
      end
    end
  end

  // Delay taps and pad controls
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      clock_out_delay <= 7'h00;
      delayed_bus_clock <= 7'h00;
      strobe_delay_low <= 7'h00;
      strobe_delay_high <= 7'h00;
      pad_cmos_mode <= 1'h0;
      impedance_sel_a <= 1'h0;
      impedance_sel_b <= 1'h0;
      drive_ohms <= `ZOUT_00;
      grant_port <= 3'h0;
    end else begin
      clock_out_delay <= clock_out_setting[`DLY_TAP_W-1:0];
      delayed_bus_clock <= command_setting[`DLY_TAP_W-1:0];
      strobe_delay_low <= strobe_low_setting[`DLY_TAP_W-1:0];
      strobe_delay_high <= strobe_high_setting[`DLY_TAP_W-1:0];
      pad_cmos_mode <= pad_mode_ctl[`PAD_MODE_BIT];
      impedance_sel_a <= impedance_ctl[1];
      impedance_sel_b <= impedance_ctl[0];
      drive_ohms <= ohms(impedance_ctl);
      grant_port <= can_grant ? pick : cur;
    end
  end

  // Memory side; mem_clk must not exceed 266 MHz, memory clock 133 MHz
  dram_link u_link (
    .mem_clk               (mem_clk),
    .srst                  (srst),
    .cmd_toggle            (req_toggle),
    .cmd_write             (c_write),
    .cmd_half              (c_half),
    .cmd_cs                (c_cs),
    .cmd_bank              (c_bank),
    .cmd_row               (c_row),
    .cmd_col               (c_col),
    .cmd_wdata             (c_wdata),
    .cmd_mask              (c_mask),
    .done_toggle           (done_toggle),
    .rd_data               (rd_data),
    .dram_clock_out        (dram_clock_out),
    .dram_clock_out_inv    (dram_clock_out_inv),
    .dram_clock_enable_out (dram_clock_enable_out),
    .dram_byte_mask        (dram_byte_mask),
    .row_strobe_n          (row_strobe_n),
    .column_strobe_n       (column_strobe_n),
    .write_strobe_n        (write_strobe_n),
    .bank_select_n         (bank_select_n),
    .dram_address_out      (dram_address_out),
    .dram_data_out         (dram_data_out),
    .dram_data_oe          (dram_data_oe),
    .dram_data_in          (dram_data_in)
  );

endmodule

// ==== test/dram_model.sv ====
// Purpose: Behavioural SDRAM on the controller memory pins
// Assumes: Commands sampled on the rising memory clock
// Notes:   Read data two clocks after its command, lines toggle otherwise
`timescale 1ns/1ps
module dram_model (
  input  wire logic [1:0]  dram_clock_out,
  input  wire logic [3:0]  bank_select_n,
  input  wire logic        row_strobe_n,
  input  wire logic        column_strobe_n,
  input  wire logic        write_strobe_n,
  input  wire logic [14:0] dram_address_out,
  input  wire logic [3:0]  dram_byte_mask,
  input  wire logic [31:0] dram_data_out,
  output logic      [31:0] dram_data_in
);
  logic [12:0] open_row [16];
  logic [31:0] mem [logic [28:0]];
  logic [31:0] rd1;
  logic [31:0] rd2;
  logic        v1 = 1'b0;
  logic        v2 = 1'b0;
  logic [31:0] wv;
  logic [1:0]  cs_idx;
  logic [3:0]  rb;
  logic [28:0] key;
  initial dram_data_in = 32'h0000_0000;
  assign cs_idx = !bank_select_n[0] ? 2'h0 : !bank_select_n[1] ? 2'h1 :
                  !bank_select_n[2] ? 2'h2 : 2'h3;
  always @(posedge dram_clock_out[0]) begin
    rb = {cs_idx, dram_address_out[14:13]};
    key = {rb, open_row[rb], dram_address_out[12:11], dram_address_out[9:0]};
    dram_data_in <= v2 ? rd2 : ~dram_data_in;
    rd2 = rd1;
    v2 = v1;
    v1 = 1'b0;
    if (bank_select_n != 4'hf) begin
      if (!row_strobe_n && column_strobe_n && write_strobe_n)
        open_row[rb] = dram_address_out[12:0];
      if (row_strobe_n && !column_strobe_n) begin
        wv = mem.exists(key) ? mem[key] : 32'h0000_0000;
        for (int i = 0; i < 4; i++)
          if (!dram_byte_mask[i] && !write_strobe_n)
            wv[8*i +: 8] = dram_data_out[8*i +: 8];
        if (!write_strobe_n)
          mem[key] = wv;
        else begin
          rd1 = wv;
          v1 = 1'b1;
        end
      end
    end
  end
endmodule

// ==== test/multiport_dram_ctrl_monitor.sv ====
// Purpose: Concurrent checks on the DRAM controller top ports
// Assumes: Bound into the controller from the bench top
// Notes:   Two domains, each property names its clock
`timescale 1ns/1ps
module multiport_dram_ctrl_monitor (
  input  wire logic            sys_clk,
  input  wire logic            srst,
  input  wire logic            mem_clk,
  input  wire logic [7:0]      hsel,
  input  wire logic [7:0][1:0] htrans,
  input  wire logic [7:0]      hready,
  input  wire logic [7:0]      hreadyout,
  input  wire logic [7:0]      clock_out_setting,
  input  wire logic [7:0]      command_setting,
  input  wire logic [7:0]      strobe_low_setting,
  input  wire logic [7:0]      strobe_high_setting,
  input  wire logic [7:0]      pad_mode_ctl,
  input  wire logic [1:0]      impedance_ctl,
  input  wire logic [6:0]      clock_out_delay,
  input  wire logic [6:0]      delayed_bus_clock,
  input  wire logic [6:0]      strobe_delay_low,
  input  wire logic [6:0]      strobe_delay_high,
  input  wire logic            pad_cmos_mode,
  input  wire logic            impedance_sel_a,
  input  wire logic            impedance_sel_b,
  input  wire logic [5:0]      drive_ohms,
  input  wire logic            busy,
  input  wire logic [2:0]      grant_port,
  input  wire logic            row_strobe_n,
  input  wire logic            column_strobe_n,
  input  wire logic            write_strobe_n,
  input  wire logic [3:0]      bank_select_n
);
  delay_taps_a: assert property (@(posedge sys_clk) disable iff (srst)
    !$past(srst) |-> {clock_out_delay, delayed_bus_clock, strobe_delay_low, strobe_delay_high}
    == $past({clock_out_setting[6:0], command_setting[6:0], strobe_low_setting[6:0],
    strobe_high_setting[6:0]})) else $error("delay tap outputs wrong");
  pad_mode_a: assert property (@(posedge sys_clk) disable iff (srst)
    !$past(srst) |-> pad_cmos_mode == $past(pad_mode_ctl[0])) else $error("pad mode wrong");
  imp_select_a: assert property (@(posedge sys_clk) disable iff (srst)
    !$past(srst) |-> {impedance_sel_a, impedance_sel_b} == $past(impedance_ctl))
    else $error("impedance select wrong");
  drive_ohms_a: assert property (@(posedge sys_clk) disable iff (srst)
    drive_ohms == 6'h19 + 6'h0a * {4'h0, impedance_sel_a, impedance_sel_b})
    else $error("drive strength wrong");
  port_reserved_a: assert property (@(posedge sys_clk) disable iff (srst)
    hreadyout[1]) else $error("reserved port answered");
  take_stall_a: assert property (@(posedge sys_clk) disable iff (srst)
    hsel[0] && hready[0] && htrans[0][1] && hreadyout[0] |=> !hreadyout[0])
    else $error("port 0 transfer not taken");
  stall_bound_a: assert property (@(posedge sys_clk) disable iff (srst)
    $fell(hreadyout[0]) |-> ##[1:300] hreadyout[0]) else $error("port 0 transfer hung");
  grant_hold_a: assert property (@(posedge sys_clk) disable iff (srst)
    busy && $past(busy) |-> $stable(grant_port)) else $error("grant moved mid transfer");
  priority_top_a: assert property (@(posedge sys_clk) disable iff (srst)
    $rose(busy) && !hreadyout[0] && !$past(hreadyout[0]) |-> grant_port == 3'h0)
    else $error("port 0 passed over");
  cs_onehot_a: assert property (@(posedge mem_clk) disable iff (srst)
    $onehot0(~bank_select_n)) else $error("several bank selects low");
  cmd_selected_a: assert property (@(posedge mem_clk) disable iff (srst)
    !row_strobe_n || !column_strobe_n || !write_strobe_n |-> bank_select_n != 4'hf)
    else $error("command strobe without select");
  cover property (@(posedge sys_clk) $rose(busy) && grant_port == 3'h7);
  cover property (@(posedge sys_clk) $rose(busy) && !hreadyout[0] && !$past(hreadyout[0]));
  cover property (@(posedge sys_clk) impedance_sel_a && impedance_sel_b);
endmodule

// ==== test/test_multiport_dram_ctrl.sv ====
// Purpose: Self-checking bench for the eight-port DRAM controller
// Assumes: Behavioural memory model on the DRAM pins
// Notes:   Inputs change on the falling sys_clk edge
`timescale 1ns/1ps
module test_multiport_dram_ctrl;
  logic             sys_clk = 1'b0;
  logic             mem_clk = 1'b0;
  logic             srst = 1'b1;
  logic [7:0]       hsel, hwrite, hready, hreadyout;
  logic [7:0][1:0]  htrans, hresp;
  logic [7:0][2:0]  hsize, hburst;
  logic [7:0][31:0] haddr, hwdata, hrdata;
  logic [1:0]       mem_mode, geo_row_sel, geo_col_sel, impedance_ctl;
  logic             geo_banks4, pad_cmos_mode, impedance_sel_a, impedance_sel_b, busy;
  logic [7:0]       clock_out_setting, command_setting, strobe_low_setting;
  logic [7:0]       strobe_high_setting, pad_mode_ctl;
  logic [6:0]       clock_out_delay, delayed_bus_clock, strobe_delay_low, strobe_delay_high;
  logic [5:0]       drive_ohms;
  logic [2:0]       grant_port, gp_d;
  logic [1:0]       dram_clock_out, dram_clock_out_inv, dram_clock_enable_out;
  logic [3:0]       dram_byte_mask, bank_select_n, cs_seen;
  logic             row_strobe_n, column_strobe_n, write_strobe_n, busy_d;
  logic [14:0]      dram_address_out;
  logic [31:0]      dram_data_out, dram_data_oe, dram_data_in;
  logic [31:0]      a_q [8];
  logic [31:0]      d_q [8];
  logic [31:0]      r_q [8];
  logic [2:0]       gq [$];
  logic [2:0]       order [4] = '{3'h0, 3'h2, 3'h3, 3'h7};
  logic [7:0]       pri_mask = 8'h8d;
  int               miscompares = 0;
  int               cmp_count = 0;
  int               cyc = 0;

  multiport_dram_ctrl i_multiport_dram_ctrl (.*);
  dram_model i_dram_model (.*);

  always #5 sys_clk = ~sys_clk;
  initial begin
    #3;
    forever #16 mem_clk = ~mem_clk;
  end
  always @(posedge mem_clk) cs_seen <= cs_seen | ~bank_select_n;
  always @(posedge sys_clk) begin
    if (busy && (!busy_d || grant_port != gp_d)) gq.push_back(grant_port);
    busy_d = busy;
    gp_d = grant_port;
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      give_verdict();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic xfer(input logic [7:0] m, input logic wr);
    int n;
    n = 0;
    @(negedge sys_clk);
    for (int p = 0; p < 8; p++) if (m[p]) begin
      {hsel[p], htrans[p], hwrite[p], haddr[p]} = {1'b1, 2'h2, wr, a_q[p]};
    end
    @(negedge sys_clk);
    for (int p = 0; p < 8; p++) if (m[p]) begin
      {hsel[p], htrans[p], hwdata[p]} = {3'h0, d_q[p]};
    end
    while (((hreadyout | ~m) != 8'hff) && n < 600) begin
      @(negedge sys_clk);
      n++;
    end
    if (n == 600) begin
      miscompares++;
      give_verdict();
    end
    for (int p = 0; p < 8; p++) r_q[p] = hrdata[p];
  endtask

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  initial begin
    {hsel, hwrite, htrans, hburst, haddr, hwdata, impedance_ctl} = '0;
    {hsize, hready, mem_mode, geo_banks4, geo_row_sel, geo_col_sel} = {{8{3'h2}}, 8'hff, 7'h19};
    {clock_out_setting, command_setting, strobe_low_setting} = {8'hd5, 8'haa, 8'h81};
    {strobe_high_setting, pad_mode_ctl} = {8'h7f, 8'hfe};
    repeat (12) @(negedge sys_clk);
    srst = 1'b0;
    check(hreadyout, 8'hff);
    check(drive_ohms, 6'h19);
    check(busy, 1'b0);
    check(hresp, 16'h0000);
    repeat (2) @(negedge sys_clk);
    check(clock_out_delay, 7'h55);
    check(delayed_bus_clock, 7'h2a);
    check(strobe_delay_low, 7'h01);
    check(strobe_delay_high, 7'h7f);
    check(pad_cmos_mode, 1'b0);
    pad_mode_ctl = 8'h01;
    for (int i = 0; i < 4; i++) begin
      impedance_ctl = i[1:0];
      repeat (2) @(negedge sys_clk);
      check({impedance_sel_a, impedance_sel_b}, i);
      check(drive_ohms, 32'h19 + 32'h0a * i);
    end
    check(pad_cmos_mode, 1'b1);
    {hsel[1], htrans[1]} = 3'h6;
    @(negedge sys_clk);
    {hsel[1], htrans[1]} = 3'h0;
    repeat (40) begin
      @(negedge sys_clk);
      check(hreadyout[1], 1'b1);
    end
    for (int g = 0; g < 3; g++) begin
      mem_mode = g[1:0];
      {geo_banks4, geo_row_sel, geo_col_sel} = (g == 0) ? 5'h19 : 5'h00;
      for (int cs = 0; cs < 4; cs++) begin
        for (int k = 0; k < 4; k++) begin
          a_q[0] = {4'h0, cs[1:0], k[0] ? ((g == 0) ? 26'h3ff_fffc : 26'h01f_fffc) : 26'h0};
          d_q[0] = {cs[7:0], g[3:0], k[3:0], 16'h5a3c};
          cs_seen = 4'h0;
          xfer(8'h01, k < 2);
          check(cs_seen, 4'h1 << cs);
          if (k >= 2) check(r_q[0], {cs[7:0], g[3:0], k[3:0] - 4'h2, 16'h5a3c});
        end
      end
    end
    mem_mode = 2'h0;
    {geo_banks4, geo_row_sel, geo_col_sel} = 5'h19;
    for (int p = 0; p < 8; p++) begin
      a_q[p] = 32'h0400_0100 + 32'h10 * p;
      d_q[p] = 32'hc0de_0000 + p;
    end
    gq.delete();
    xfer(pri_mask, 1'b1);
    xfer(pri_mask, 1'b0);
    check(gq.size(), 8);
    for (int i = 0; i < 8; i++) if (i < gq.size()) check(gq[i], order[i % 4]);
    for (int p = 0; p < 8; p++) if (pri_mask[p]) check(r_q[p], d_q[p]);
    check({dram_clock_enable_out, dram_clock_out ^ dram_clock_out_inv}, 4'hf);
    check(dram_data_oe, 32'h0000_0000);
    give_verdict();
  end
endmodule

bind multiport_dram_ctrl multiport_dram_ctrl_monitor i_multiport_dram_ctrl_monitor (.*);
